// file: design/voltage_monitor_loop.sv
// Voltage monitor loop: converter sequencing, readings, limits, core-low
//
// Overview of operation
// - One shared converter gives 10-bit results
// - Nominal rail reads three quarters full scale
// - Extended read freezes matching readings until read
// - Config-seven bit 2 includes reference channel
// - Select bits 3..7 include five rails
// - Loop skips every unselected channel
// - Bypassed inputs use 2 V reference
// - Attenuated channels have fixed code weights
// - Reading beyond limit sets channel status
// - Out-of-limit channel can assert alert
// - Averaging length 4 to 32 samples
// - Config-two bit 3 turns averaging off
// - Bypass bits 3..7 skip channel attenuators
// - Own supply attenuator never bypassed
// - Readings are zero after reset
// - Config-six bit 6 enables core-low mode
// - Core below low limit suspends other functions
// - Core back above limit resumes functions
// - Status stays set until its register read
// - Summary bit 0 shows any limit status
`timescale 1ns/1ps
module voltage_monitor_loop (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Register access from the slave port front end
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Shared converter
  output logic            adc_start,
  output logic      [2:0] adc_chan,
  output logic            adc_bypass,
  input  wire logic       adc_done,
  input  wire logic [9:0] adc_result,
  // Alert and suspension of other functions
  output logic            alert_output_n,
  output logic            functions_suspend,
  output logic            error_clear
);

  localparam int N = vmon_pkg::NUM_CH;

  // Configuration registers
  logic [7:0] config_six;              // Core-low enable
  logic [7:0] config_seven;            // Reference channel include
  logic [7:0] channel_select_config;   // Rail includes
  logic [7:0] averaging_config;        // Averaging length
  logic [7:0] config_two;              // Averaging off
  logic [7:0] attenuator_bypass_config;// Attenuator bypass
  logic [7:0] status_mask;             // Alert mask

  // Per-channel state
  logic [7:0] low_lim  [N];            // Low limits
  logic [7:0] high_lim [N];            // High limits
  logic [9:0] reading  [N];            // Shown results
  logic       lock     [N];            // Frozen by extended read
  logic       stat     [N];            // Sticky out-of-limit bits
  logic [N-1:0] chan_en;               // Channels in the loop
  logic [N-1:0] stat_vec;              // Status as a vector
  logic [N-1:0] bypass_vec;            // Bypass per channel

  // Sequencer
  vmon_pkg::seq_state_t state;         // Current state
  logic [2:0]  cur_ch;                 // Channel being converted
  logic [14:0] acc;                    // Sample accumulator
  logic [5:0]  samp_cnt;               // Samples taken
  logic [5:0]  samp_total;             // Samples needed
  logic [9:0]  final_res;              // Finished result
  logic        store;                  // One-cycle result strobe
  logic        avg_off;                // Single-sample mode
  logic [1:0]  avg_code;               // Averaging length code
  logic [15:0] sum_next;               // Accumulator plus sample
  logic [2:0]  next_ch;                // Next enabled channel

  // Core-low mode
  logic core_low;                      // Core under its low limit
  logic core_low_d;                    // Previous value for edge

  // Read strobe and status summary
  logic rd_status;                     // Limit status register read
  logic any_stat_set;                  // A status bit is set

  // Channel enables from the configuration
  always_comb begin
    chan_en[vmon_pkg::CH_REF] =
      config_seven[vmon_pkg::REF_INCLUDE_BIT];
    chan_en[vmon_pkg::CH_12V]  = channel_select_config[3];
    chan_en[vmon_pkg::CH_5V]   = channel_select_config[4];
    chan_en[vmon_pkg::CH_CORE] = channel_select_config[5];
    chan_en[vmon_pkg::CH_2V5]  = channel_select_config[6];
    chan_en[vmon_pkg::CH_OWN]  = channel_select_config[7];
  end

  // Attenuator bypass per channel; own supply is always attenuated
  always_comb begin
    bypass_vec[vmon_pkg::CH_REF]  = attenuator_bypass_config[3];
    bypass_vec[vmon_pkg::CH_2V5]  = attenuator_bypass_config[4];
    bypass_vec[vmon_pkg::CH_CORE] = attenuator_bypass_config[5];
    bypass_vec[vmon_pkg::CH_5V]   = attenuator_bypass_config[6];
    bypass_vec[vmon_pkg::CH_12V]  = attenuator_bypass_config[7];
    bypass_vec[vmon_pkg::CH_OWN]  = 1'b0;
  end

  // Pick the next enabled channel after the current one, round robin
  function automatic logic [2:0] pick_next(input logic [2:0] cur,
                                           input logic [N-1:0] en);
    logic [2:0] idx;
    logic [2:0] sel;
    sel = cur;
    for (int k = N; k >= 1; k--) begin
      idx = 3'((int'(cur) + k) % N);
      if (en[idx]) begin
        sel = idx;
      end
    end
    return sel;
  endfunction

  // Averaging settings
  always_comb begin
    avg_off    = config_two[vmon_pkg::AVG_OFF_BIT];
    avg_code   = averaging_config[vmon_pkg::AVG_LEN_MSB:
                                  vmon_pkg::AVG_LEN_LSB];
    samp_total = avg_off ? 6'h01
                         : 6'(vmon_pkg::MIN_SAMPLES << avg_code);
    sum_next   = {1'b0, acc} + {6'h00, adc_result};
    next_ch    = pick_next(cur_ch, chan_en);
  end

  // Converter drive: a start pulse, the channel and its bypass
  always_comb begin
    adc_start  = (state == vmon_pkg::SEQ_START);
    adc_chan   = cur_ch;
    adc_bypass = bypass_vec[cur_ch];
  end

  // Conversion sequencer walking the enabled channels
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state     <= vmon_pkg::SEQ_IDLE;
      cur_ch    <= 3'h0;
      acc       <= 15'h0000;
      samp_cnt  <= 6'h00;
      final_res <= vmon_pkg::RST_READING;
    end else begin
      case (state)
        // Wait for any channel to be included
        vmon_pkg::SEQ_IDLE: begin
          if (|chan_en) begin
            cur_ch <= next_ch;
            state  <= vmon_pkg::SEQ_START;
          end
        end
        // One-cycle start request to the converter
        vmon_pkg::SEQ_START: begin
          state <= vmon_pkg::SEQ_WAIT;
        end
        // Gather samples until the averaging length is reached
        vmon_pkg::SEQ_WAIT: begin
          if (adc_done) begin
            // Greater-or-equal ends a reading cut short by a shorter length
            if (samp_cnt + 6'h01 >= samp_total) begin
              if (avg_off) begin
                final_res <= adc_result;
              end else begin
                // Shift amount widened so codes 2 and 3 do not wrap
                final_res <= 10'(sum_next >> (3'(avg_code) + 3'd2));
              end
              acc      <= 15'h0000;
              samp_cnt <= 6'h00;
              state    <= vmon_pkg::SEQ_STORE;
            end else begin
              acc      <= sum_next[14:0];
              samp_cnt <= samp_cnt + 6'h01;
              state    <= vmon_pkg::SEQ_START;
            end
          end
        end
        // Result is published; move on or rest if nothing enabled
        vmon_pkg::SEQ_STORE: begin
          cur_ch <= next_ch;
          state  <= (|chan_en) ? vmon_pkg::SEQ_START
                               : vmon_pkg::SEQ_IDLE;
        end
        default: begin
          state <= vmon_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  assign store = (state == vmon_pkg::SEQ_STORE);

  // Configuration register writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      config_six               <= vmon_pkg::RST_CONFIG;
      config_seven             <= vmon_pkg::RST_CONFIG;
      channel_select_config    <= vmon_pkg::RST_SELECT;
      averaging_config         <= vmon_pkg::RST_CONFIG;
      config_two               <= vmon_pkg::RST_CONFIG;
      attenuator_bypass_config <= vmon_pkg::RST_CONFIG;
      status_mask              <= vmon_pkg::RST_MASK;
    end else if (reg_wr) begin
      case (reg_addr)
        vmon_pkg::ADDR_CONFIG_SIX:    config_six <= reg_wdata;
        vmon_pkg::ADDR_CONFIG_SEVEN:  config_seven <= reg_wdata;
        vmon_pkg::ADDR_CHANNEL_SEL:   channel_select_config <= reg_wdata;
        vmon_pkg::ADDR_AVERAGING:     averaging_config <= reg_wdata;
        vmon_pkg::ADDR_CONFIG_TWO:    config_two <= reg_wdata;
        vmon_pkg::ADDR_STATUS_MASK:   status_mask <= reg_wdata;
        vmon_pkg::ADDR_BYPASS_CONFIG: begin
          attenuator_bypass_config <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  assign rd_status = reg_rd && (reg_addr == vmon_pkg::ADDR_LIMIT_STATUS);

  // Per-channel limits, readings, read lock and sticky status
  for (genvar i = 0; i < N; i++) begin : g_ch
    logic hit;                         // Store for this channel
    logic out_of_limit;                // Result beyond a limit
    assign hit = store && (cur_ch == 3'(i));
    assign out_of_limit = (final_res[9:2] > high_lim[i]) ||
                          (final_res[9:2] < low_lim[i]);

    // Limit registers
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        low_lim[i]  <= vmon_pkg::RST_LOW_LIM;
        high_lim[i] <= vmon_pkg::RST_HIGH_LIM;
      end else if (reg_wr) begin
        if (reg_addr == vmon_pkg::LOW_ADDR[i]) begin
          low_lim[i] <= reg_wdata;
        end
        if (reg_addr == vmon_pkg::HIGH_ADDR[i]) begin
          high_lim[i] <= reg_wdata;
        end
      end
    end

    // Lock set by extended read, released by reading the main byte
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        lock[i] <= 1'b0;
      end else if (reg_rd && reg_addr == vmon_pkg::EXT_ADDR[i]) begin
        lock[i] <= 1'b1;
      end else if (reg_rd && reg_addr == vmon_pkg::READ_ADDR[i]) begin
        lock[i] <= 1'b0;
      end
    end

    // Shown reading, held while locked
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        reading[i] <= vmon_pkg::RST_READING;
      end else if (hit && !lock[i]) begin
        reading[i] <= final_res;
      end
    end

    // Sticky status: a new event wins over the clearing read
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        stat[i] <= 1'b0;
      end else if (hit && out_of_limit) begin
        stat[i] <= 1'b1;
      end else if (rd_status) begin
        stat[i] <= 1'b0;
      end
    end

    assign stat_vec[i] = stat[i];

    // Out-of-limit result must set the status bit next cycle
    chan_stat_a: assert property (@(posedge ref_clk) disable iff (rst)
      hit && out_of_limit |=> stat[i])
      else $error("status bit missed an out-of-limit reading");
    // A locked reading must not change on a new result
    chan_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
      lock[i] && !reg_rd |=> $stable(reading[i]))
      else $error("locked reading changed");
  end

  assign any_stat_set = |stat_vec;

  // Core-low detection on each core result while the mode is on
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_low <= 1'b0;
    end else if (!config_six[vmon_pkg::CORE_LOW_EN_BIT]) begin
      core_low <= 1'b0;
    end else if (store && cur_ch == 3'(vmon_pkg::CH_CORE)) begin
      core_low <= final_res[9:2] < low_lim[vmon_pkg::CH_CORE];
    end
  end

  // Suspension level and one-cycle error clear on entering core-low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_low_d        <= 1'b0;
      functions_suspend <= 1'b0;
      error_clear       <= 1'b0;
    end else begin
      core_low_d        <= core_low;
      functions_suspend <= core_low;
      error_clear       <= core_low && !core_low_d;
    end
  end

  // Alert: any unmasked status bit drives the pin low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alert_output_n <= 1'b1;
    end else begin
      alert_output_n <= ~|(stat_vec & ~status_mask[N-1:0]);
    end
  end

  // Register read data, registered one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
      case (reg_addr)
        vmon_pkg::ADDR_CONFIG_SIX:    reg_rdata <= config_six;
        vmon_pkg::ADDR_CONFIG_SEVEN:  reg_rdata <= config_seven;
        vmon_pkg::ADDR_SUMMARY:       reg_rdata <= {7'h00, any_stat_set};
        vmon_pkg::ADDR_CHANNEL_SEL:   reg_rdata <= channel_select_config;
        vmon_pkg::ADDR_AVERAGING:     reg_rdata <= averaging_config;
        vmon_pkg::ADDR_LIMIT_STATUS:  reg_rdata <= {2'b00, stat_vec};
        vmon_pkg::ADDR_CONFIG_TWO:    reg_rdata <= config_two;
        vmon_pkg::ADDR_STATUS_MASK:   reg_rdata <= status_mask;
        vmon_pkg::ADDR_BYPASS_CONFIG: begin
          reg_rdata <= attenuator_bypass_config;
        end
        default: begin
          for (int j = 0; j < N; j++) begin
            if (reg_addr == vmon_pkg::READ_ADDR[j]) begin
              reg_rdata <= reading[j][9:2];
            end
            if (reg_addr == vmon_pkg::LOW_ADDR[j]) begin
              reg_rdata <= low_lim[j];
            end
            if (reg_addr == vmon_pkg::HIGH_ADDR[j]) begin
              reg_rdata <= high_lim[j];
            end
          end
        end
      endcase
      // Extended registers gather the two low bits of several channels
      for (int j = 0; j < N; j++) begin
        if (reg_addr == vmon_pkg::EXT_ADDR[j]) begin
          reg_rdata[vmon_pkg::EXT_POS[j] +: 2] <= reading[j][1:0];
        end
      end
    end
  end

  // Converter is only started on an enabled channel
  skip_disabled_a: assert property (@(posedge ref_clk) disable iff (rst)
    adc_start && $stable(chan_en) |-> chan_en[adc_chan])
    else $error("converter started on an excluded channel");
  // Reference channel excluded when its include bit is clear
  ref_include_a: assert property (@(posedge ref_clk) disable iff (rst)
    adc_start && $stable(config_seven) && !config_seven[2]
      |-> adc_chan != 3'h0)
    else $error("reference channel converted while excluded");
  // Own supply never bypassed
  own_bypass_a: assert property (@(posedge ref_clk) disable iff (rst)
    adc_chan == 3'h3 |-> !adc_bypass)
    else $error("own supply attenuator bypassed");
  // 12 V bypass follows its bit
  bypass_12v_a: assert property (@(posedge ref_clk) disable iff (rst)
    adc_start && adc_chan == 3'h5 |->
      adc_bypass == attenuator_bypass_config[7])
    else $error("12 V bypass does not follow its bit");
  // Single conversion per reading with averaging off
  avg_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    state == vmon_pkg::SEQ_WAIT && adc_done && config_two[3]
      |=> state == vmon_pkg::SEQ_STORE)
    else $error("averaging not bypassed");
  // Sample count follows the length code
  avg_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    !config_two[3] |-> samp_total == (6'h04 << averaging_config[7:6]))
    else $error("wrong averaging length");
  // Summary bit mirrors the limit status
  summary_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == 8'h12 |=> reg_rdata[0] == $past(any_stat_set))
    else $error("summary bit wrong");
  // Status cleared by its read when nothing new sets it
  status_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_status && !store |=> !any_stat_set)
    else $error("status not cleared by read");
  // Core-low suspends on the next cycle and clears errors once
  core_suspend_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(core_low) |=> functions_suspend && error_clear)
    else $error("core-low did not suspend functions");
  // Leaving core-low releases the suspension next cycle
  core_resume_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(core_low) |=> !functions_suspend)
    else $error("functions not resumed");

endmodule

// file: design/vmon_pkg.sv
// Package with register map, channel indices and sequencer states
package vmon_pkg;
  // Register offsets for configuration and status
  localparam logic [7:0] ADDR_CONFIG_SIX    = 8'h10;
  localparam logic [7:0] ADDR_CONFIG_SEVEN  = 8'h11;
  localparam logic [7:0] ADDR_SUMMARY       = 8'h12;
  localparam logic [7:0] ADDR_CHANNEL_SEL   = 8'h13;
  localparam logic [7:0] ADDR_EXT_RES_A     = 8'h1F;
  localparam logic [7:0] ADDR_AVERAGING     = 8'h40;
  localparam logic [7:0] ADDR_LIMIT_STATUS  = 8'h41;
  localparam logic [7:0] ADDR_CONFIG_TWO    = 8'h73;
  localparam logic [7:0] ADDR_STATUS_MASK   = 8'h74;
  localparam logic [7:0] ADDR_EXT_RES_B     = 8'h76;
  localparam logic [7:0] ADDR_EXT_RES_C     = 8'h77;
  localparam logic [7:0] ADDR_BYPASS_CONFIG = 8'h7D;
  // Channel indices
  localparam int NUM_CH  = 6;
  localparam int CH_REF  = 0;
  localparam int CH_2V5  = 1;
  localparam int CH_CORE = 2;
  localparam int CH_OWN  = 3;
  localparam int CH_5V   = 4;
  localparam int CH_12V  = 5;
  // Per-channel reading, low limit and high limit offsets
  localparam logic [7:0] READ_ADDR [NUM_CH] =
    '{8'h1E, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24};
  localparam logic [7:0] LOW_ADDR [NUM_CH] =
    '{8'h84, 8'h44, 8'h46, 8'h48, 8'h4A, 8'h4C};
  localparam logic [7:0] HIGH_ADDR [NUM_CH] =
    '{8'h86, 8'h45, 8'h47, 8'h49, 8'h4B, 8'h4D};
  // Extended register that holds each channel's two low bits
  localparam logic [7:0] EXT_ADDR [NUM_CH] =
    '{8'h1F, 8'h76, 8'h76, 8'h76, 8'h76, 8'h77};
  // Bit position of those two bits inside the extended register
  localparam int EXT_POS [NUM_CH] = '{4, 0, 2, 4, 6, 0};
  // Field positions
  localparam int CORE_LOW_EN_BIT = 6;
  localparam int REF_INCLUDE_BIT = 2;
  localparam int SEL_BASE_BIT    = 3;
  localparam int AVG_OFF_BIT     = 3;
  localparam int AVG_LEN_MSB     = 7;
  localparam int AVG_LEN_LSB     = 6;
  // Values after reset
  localparam logic [7:0] RST_CONFIG   = 8'h00;
  localparam logic [7:0] RST_SELECT   = 8'hF8;
  localparam logic [7:0] RST_MASK     = 8'h00;
  localparam logic [7:0] RST_LOW_LIM  = 8'h00;
  localparam logic [7:0] RST_HIGH_LIM = 8'hFF;
  localparam logic [9:0] RST_READING  = 10'h000;
  // Converter scale: nominal rail gives three quarters of full scale
  localparam int        ADC_BITS      = 10;
  localparam logic [9:0] NOMINAL_CODE = 10'h300;
  // Code weights in microvolts per lsb
  localparam int UV_BYPASSED = 1953;
  localparam int UV_12V      = 15920;
  localparam int UV_5V       = 6540;
  localparam int UV_2V5      = 3260;
  localparam int UV_CORE     = 2930;
  localparam int UV_OWN      = 4290;
  localparam int UV_REF      = 2200;
  // Fewest samples in an averaged reading
  localparam logic [5:0] MIN_SAMPLES = 6'h04;
  // Conversion sequencer states, Gray coded in the order idle, start, wait, store
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_START = 2'b01,
    SEQ_WAIT  = 2'b11,
    SEQ_STORE = 2'b10
  } seq_state_t;
endpackage

// file: verif/rail_adc_model.sv
// Behavioural model of the shared converter and its analog rails
`timescale 1ns/1ps
module rail_adc_model (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst,
  // Conversion request from the block
  input  wire logic            adc_start,
  input  wire logic [2:0]      adc_chan,
  // Rail codes and conversion latency set by the bench
  input  wire logic [5:0][9:0] rail,
  input  wire logic [7:0]      lat,
  // Result back to the block
  output logic                 adc_done,
  output logic      [9:0]      adc_result
);
  logic [7:0] cnt;  // Cycles left in the running conversion

  // Latency counter, loaded when a sample is requested
  always @(posedge ref_clk) begin
    if (rst) begin
      cnt <= 8'h00;
    end else if (adc_start) begin
      cnt <= lat;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end

  // One-cycle done pulse at the end of the latency
  assign adc_done = (cnt == 8'h01);
  // Ten-bit sample; outside the pulse the bus shows the inverse pattern
  assign adc_result = adc_done ? rail[adc_chan] : ~rail[adc_chan];
endmodule

// file: verif/tb.sv
// Self-checking bench for the voltage monitor loop
`timescale 1ns/1ps
module tb;
  logic            ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic [7:0]      reg_addr = 0, reg_wdata = 0, lat = 30, byp = 0;
  logic [7:0]      reg_rdata;
  logic [2:0]      adc_chan;
  logic            adc_start, adc_bypass, adc_done, alert_output_n;
  logic            functions_suspend, error_clear;
  logic [9:0]      adc_result, old;
  logic [5:0][9:0] rail = '0;
  logic [7:0]      exp_q[$];  // Expected read data, oldest first
  int n_errors = 0, total_checks = 0, gap = 0, run = 0, run_len = 0;
  int ec_n = 0, i, k;
  int cnt_ch[6];  // Samples requested per channel
  localparam int BPOS[6] = '{3, 4, 5, 0, 6, 7};
  localparam int SEL_CH[6] = '{5, 4, 2, 1, 3, 0};

  // Clock
  always #2 ref_clk = ~ref_clk;

  voltage_monitor_loop DUT (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_bypass(adc_bypass), .adc_done(adc_done),
    .adc_result(adc_result), .alert_output_n(alert_output_n),
    .functions_suspend(functions_suspend), .error_clear(error_clear));
  rail_adc_model adc (.ref_clk(ref_clk), .rst(rst), .adc_start(adc_start),
    .adc_chan(adc_chan), .rail(rail), .lat(lat), .adc_done(adc_done),
    .adc_result(adc_result));

  // Compare and count
  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task conclude;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One-cycle register write
  task wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge ref_clk);
    #1;
    reg_wr = 0;
  endtask
  // One-cycle register read, expected value noted for the monitor
  task rd(input logic [7:0] a, e);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    #1;
    reg_rd = 0;
  endtask

  // Monitor: read data, sample requests, bypass, run length, clear pulses
  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk(reg_rdata, exp_q.pop_front());
    gap++;
    if (error_clear === 1'b1) ec_n++;
    if (adc_start === 1'b1) begin
      cnt_ch[adc_chan]++;
      chk(adc_bypass, adc_chan != 3 && byp[BPOS[adc_chan]]);
      if (gap > lat + 1) begin
        run_len = run;
        run = 0;
      end
      run++;
      gap = 0;
    end
  end

  // Hang guard
  initial begin
    #40000;
    n_errors++;
    conclude;
  end

  initial begin
    void'($urandom(53));
    cyc(4);
    rst = 0;
    for (i = 0; i < 6; i++) rd(vmon_pkg::READ_ADDR[i], 8'h00);
    wr(vmon_pkg::ADDR_BYPASS_CONFIG, 8'hF8);
    byp = 8'hF8;
    wr(vmon_pkg::ADDR_CONFIG_TWO, 8'h08);
    lat = 3;
    // Extended read locks the core reading while the rail moves
    for (i = 0; i < 6; i++) rail[i] = 10'($urandom % 1024);
    cyc(200);
    rd(8'h76, {rail[4][1:0], rail[3][1:0], rail[2][1:0], rail[1][1:0]});
    old = rail[2];
    rail[2] = ~old;
    cyc(100);
    rd(8'h21, old[9:2]);
    cyc(100);
    rd(8'h21, ~old[9:2]);
    // Each channel alone in the loop
    for (k = 0; k < 6; k++) begin
      wr(vmon_pkg::ADDR_CONFIG_SEVEN, k == 5 ? 8'h04 : 8'h00);
      wr(vmon_pkg::ADDR_CHANNEL_SEL, k == 5 ? 8'h00 : 8'(1 << (k + 3)));
      cyc(30);
      cnt_ch = '{default: 0};
      cyc(60);
      for (i = 0; i < 6; i++) chk(cnt_ch[i] > 0, i == SEL_CH[k]);
    end
    // Samples per reading for every averaging code
    wr(vmon_pkg::ADDR_CHANNEL_SEL, 8'h08);
    wr(vmon_pkg::ADDR_CONFIG_TWO, 8'h00);
    for (k = 0; k < 4; k++) begin
      wr(vmon_pkg::ADDR_AVERAGING, 8'(k << 6));
      cyc(400);
      chk(16'(run_len), 16'(4 << k));
    end
    rd(8'h24, rail[5][9:2]);
    wr(vmon_pkg::ADDR_CONFIG_TWO, 8'h08);
    cyc(50);
    chk(16'(run_len), 16'h0001);
    wr(vmon_pkg::ADDR_CHANNEL_SEL, 8'hF8);
    // High limit: equal passes, above flags, flag sticks until read
    rail[1] = 10'h200;
    wr(8'h45, 8'h80);
    cyc(100);
    rd(vmon_pkg::ADDR_LIMIT_STATUS, 8'h00);
    chk(alert_output_n, 1'b1);
    rail[1] = 10'h204;
    cyc(100);
    chk(alert_output_n, 1'b0);
    rd(vmon_pkg::ADDR_SUMMARY, 8'h01);
    rail[1] = 10'h1FC;
    cyc(100);
    rd(vmon_pkg::ADDR_LIMIT_STATUS, 8'h02);
    rd(vmon_pkg::ADDR_LIMIT_STATUS, 8'h00);
    // Core-low mode entry and exit
    wr(8'h46, 8'h80);
    rail[2] = 10'h1FC;
    ec_n = 0;
    wr(vmon_pkg::ADDR_CONFIG_SIX, 8'h40);
    for (i = 0; i < 200 && functions_suspend !== 1'b1; i++) cyc(1);
    chk(functions_suspend, 1'b1);
    cyc(100);
    chk(16'(ec_n), 16'h0001);
    rd(vmon_pkg::ADDR_LIMIT_STATUS, 8'h04);
    rail[2] = 10'h200;
    for (i = 0; i < 200 && functions_suspend !== 1'b0; i++) cyc(1);
    chk(functions_suspend, 1'b0);
    conclude;
  end
endmodule
